// [rtl/wd_pkg.sv]
// Shared constants and types of the watchdog timer block.
// Assumes a byte-wide register map reached over a 32-bit bus.
package wd_pkg;

  localparam int unsigned WD_DW = 32;

  // Register indices; byte address is four times the index
  localparam logic [7:0] WD_IDX_CTL_TWO = 8'hAB;
  localparam logic [7:0] WD_IDX_CTL_ONE = 8'hD8;
  localparam logic [7:0] WD_IDX_INT_EN  = 8'hE8;
  localparam logic [7:0] WD_IDX_KEY     = 8'hC7;

  // Timed-access key values
  localparam logic [7:0] WD_KEY_FIRST  = 8'hAA;
  localparam logic [7:0] WD_KEY_SECOND = 8'h55;

  // Field positions
  localparam int unsigned WD_BIT_RUN   = 7;
  localparam int unsigned WD_BIT_CLR   = 6;
  localparam int unsigned WD_BIT_FLAG  = 5;
  localparam int unsigned WD_BIT_SLEEP = 4;
  localparam int unsigned WD_BIT_RSTF  = 3;
  localparam int unsigned WD_PS_MSB    = 2;
  localparam int unsigned WD_BIT_RFE   = 0;
  localparam int unsigned WD_BIT_EWDI  = 4;

  // Reset values
  localparam logic [7:0] WD_CTL_ONE_RST = 8'h00;
  localparam logic       WD_RFE_RST     = 1'b0;
  localparam logic       WD_EWDI_RST    = 1'b0;

  // Timing in low-speed clock ticks
  localparam int unsigned WD_BASE_TICKS  = 64;
  localparam int unsigned WD_GRACE_TICKS = 512;
  localparam int unsigned WD_CNT_W       = 15;
  localparam int unsigned WD_GRACE_W     = 9;
  localparam logic [WD_GRACE_W-1:0] WD_GRACE_LAST = WD_GRACE_W'(WD_GRACE_TICKS - 1);

  typedef struct packed {
    logic       run_en;
    logic       clr;
    logic       flag;
    logic       sleep_run;
    logic       rst_flag;
    logic [2:0] ps;
  } wd_ctl_one_t;

  typedef enum logic [0:0] {
    WD_ST_RUN   = 1'b0,
    WD_ST_GRACE = 1'b1
  } wd_state_t;

  // Prescale code to shift for ratios 1,2,8,16,32,64,128,256
  function automatic logic [3:0] wd_ps_shift(input logic [2:0] code);
    case (code)
      3'h0:    wd_ps_shift = 4'h0;
      3'h1:    wd_ps_shift = 4'h1;
      default: wd_ps_shift = 4'({1'b0, code} + 4'h1);
    endcase
  endfunction : wd_ps_shift

endpackage : wd_pkg

// [rtl/wd_tick_cnt.sv]
// Watchdog counter of low-speed ticks with selectable time-out.
// Assumes tick_i is a one-cycle pulse per low-speed clock.
`timescale 1ns/1ns
module wd_tick_cnt #(
  parameter int unsigned CNT_W = wd_pkg::WD_CNT_W
) (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       clear_i,
  input  wire logic       run_i,
  input  wire logic       tick_i,
  input  wire logic [2:0] ps_i,
  output logic            timeout_o
);
  import wd_pkg::*;

  if (CNT_W < WD_CNT_W) begin : g_chk
    $error("Counter too narrow for longest time-out");
  end

  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic [CNT_W-1:0] last;

  assign last      = (CNT_W'(WD_BASE_TICKS) << wd_ps_shift(ps_i)) - CNT_W'(1);
  assign timeout_o = run_i & tick_i & ~clear_i & (cnt_q == last);

  always_comb begin
    cnt_d = cnt_q;
    if (clear_i) begin
      cnt_d = '0;
    end else if (run_i & tick_i) begin
      cnt_d = timeout_o ? '0 : cnt_q + CNT_W'(1);
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  a_clear_zeroes_cnt: assert property (clear_i |=> cnt_q == '0)
    else $error("Counter not zero after clear");
  a_run_counts_up: assert property (run_i && tick_i && !clear_i && !timeout_o |=> cnt_q == $past(cnt_q) + CNT_W'(1))
    else $error("Counter failed to advance");
  a_timeout_wraps: assert property (timeout_o |=> cnt_q == '0 && $past(cnt_q) == $past(last))
    else $error("Time-out at wrong count");

endmodule : wd_tick_cnt

// [rtl/wd_unlock.sv]
// Timed-access gate: two key writes open the next write only.
// Assumes wr_i pulses once per accepted bus write.
`timescale 1ns/1ns
module wd_unlock (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       wr_i,
  input  wire logic       key_wr_i,
  input  wire logic [7:0] data_i,
  output logic            unlocked_o
);
  import wd_pkg::*;

  logic armed_q;
  logic armed_d;
  logic open_q;
  logic open_d;

  always_comb begin
    armed_d = armed_q;
    open_d  = open_q;
    if (wr_i) begin
      armed_d = key_wr_i & (data_i == WD_KEY_FIRST);
      open_d  = key_wr_i & armed_q & (data_i == WD_KEY_SECOND);
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      armed_q <= 1'b0;
      open_q  <= 1'b0;
    end else begin
      armed_q <= armed_d;
      open_q  <= open_d;
    end
  end

  assign unlocked_o = open_q;

  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  a_open_needs_key: assert property ($rose(open_q) |-> $past(armed_q) && $past(key_wr_i))
    else $error("Gate opened without key pair");

endmodule : wd_unlock

// [rtl/wd_watchdog.sv]
// Watchdog timer with timed-access control and Wishbone slave.
// Assumes LS_TICK_I pulses once per low-speed clock, all inputs
// synchronous to REF_CLK_I, RESET_N_I is the power-on reset.
// Operation
// - Writing one to clear bit zeroes counter; bit reads back zero.
// - Clearing run enable stops the watchdog and zeroes its counter.
// - With run enable set the counter counts low-speed ticks.
// - Three-bit prescale field picks the time-out interval.
// - Time-out sets the flag in control bit five.
// - With reset function on, reset follows 512 ticks after time-out.
// - During those 512 ticks a counter clear cancels the reset.
// - Time-out wakes from idle or power down and raises interrupt event.
// - Run-in-sleep bit: 0 halts counter in sleep, 1 keeps counting.
// - Counter clears on entering and leaving idle or power down.
// - Reset flag set by watchdog reset, cleared by power-on or software.
// - Every reset loads run enable with inverse of nonvolatile bit.
// - Run-in-sleep and prescale clear only at power-on reset.
// - Bit zero of control two enables the reset function.
// - Reset function enable clears only at power-on reset.
// - Interrupt reaches the core only when its enable bit is set.
// - Time-out is 64 ticks times prescale ratio, one to 256.
// - Control writes need key values AA then 55 just before.
//
// The Wishbone interface to the registers was left to the implementer.
`timescale 1ns/1ns
module wd_watchdog (
  input  wire logic                    REF_CLK_I,
  input  wire logic                    RESET_N_I,
  input  wire logic                    WB_CYC_I,
  input  wire logic                    WB_STB_I,
  input  wire logic                    WB_WE_I,
  input  wire logic [9:0]              WB_ADR_I,
  input  wire logic [3:0]              WB_SEL_I,
  input  wire logic [wd_pkg::WD_DW-1:0] WB_DAT_I,
  output logic      [wd_pkg::WD_DW-1:0] WB_DAT_O,
  output logic                         WB_ACK_O,
  input  wire logic                    LS_TICK_I,
  input  wire logic                    IDLE_I,
  input  wire logic                    PDOWN_I,
  input  wire logic                    NV_WDOG_DISABLE_I,
  input  wire logic                    OTHER_RESET_I,
  output logic                         IRQ_O,
  output logic                         WAKE_O,
  output logic                         SYS_RESET_O
);
  import wd_pkg::*;

  function automatic logic idx_hit(input logic [7:0] a, input logic [7:0] b);
    idx_hit = (a == b);
  endfunction : idx_hit

  logic             acc;
  logic             wr;
  logic [7:0]       idx;
  logic [7:0]       wdat;
  logic             unlocked;
  logic             ctl_wr;
  logic             rfe_wr;
  logic             tmo;
  logic             sleep;
  logic             sleep_edge;
  logic             soft_rst;
  logic             sw_clr;
  logic             cnt_clr;
  logic             run_gate;
  logic             expire;

  wd_ctl_one_t      ctl_q;
  wd_ctl_one_t      ctl_d;
  logic             rfe_q;
  logic             rfe_d;
  logic             ewdi_q;
  logic             ewdi_d;
  logic             init_q;
  logic             sleep_q;

  wd_state_t        st_q;
  wd_state_t        st_d;
  logic [WD_GRACE_W-1:0] grace_q;
  logic [WD_GRACE_W-1:0] grace_d;

  logic             ack_d;
  logic [WD_DW-1:0] dat_d;
  logic             irq_d;

  // Bus decode
  assign acc    = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
  // Write lands at the edge where the master sees ack high
  assign wr     = WB_CYC_I & WB_STB_I & WB_ACK_O & WB_WE_I & WB_SEL_I[0];
  assign idx    = WB_ADR_I[9:2];
  assign wdat   = WB_DAT_I[7:0];

  assign ctl_wr = wr & unlocked & idx_hit(idx, WD_IDX_CTL_ONE);
  assign rfe_wr = wr & unlocked & idx_hit(idx, WD_IDX_CTL_TWO);

  wd_unlock u_unlock (
    .clk_i      (REF_CLK_I),
    .rst_n_i    (RESET_N_I),
    .wr_i       (wr),
    .key_wr_i   (wr & idx_hit(idx, WD_IDX_KEY)),
    .data_i     (wdat),
    .unlocked_o (unlocked)
  );

  // Other resets: first cycle after power-on, pin, own expiry
  assign soft_rst   = init_q | OTHER_RESET_I | SYS_RESET_O;
  assign sleep      = IDLE_I | PDOWN_I;
  assign sleep_edge = sleep ^ sleep_q;

  assign sw_clr   = ctl_wr & wdat[WD_BIT_CLR];
  // Clear on sleep entry and exit
  assign cnt_clr  = sw_clr | ~ctl_q.run_en | sleep_edge | soft_rst;
  assign run_gate = ctl_q.run_en & (~sleep | ctl_q.sleep_run);

  wd_tick_cnt #(
    .CNT_W (WD_CNT_W)
  ) u_cnt (
    .clk_i     (REF_CLK_I),
    .rst_n_i   (RESET_N_I),
    .clear_i   (cnt_clr),
    .run_i     (run_gate),
    .tick_i    (LS_TICK_I),
    .ps_i      (ctl_q.ps),
    .timeout_o (tmo)
  );

  // Control registers
  always_comb begin
    ctl_d  = ctl_q;
    rfe_d  = rfe_q;
    ewdi_d = ewdi_q;
    if (ctl_wr) begin
      ctl_d.run_en    = wdat[WD_BIT_RUN];
      ctl_d.sleep_run = wdat[WD_BIT_SLEEP];
      ctl_d.ps        = wdat[WD_PS_MSB:0];
      // A zero write or any reset clears flag
      if (!wdat[WD_BIT_FLAG]) begin
        ctl_d.flag = 1'b0;
      end
      if (!wdat[WD_BIT_RSTF]) begin
        ctl_d.rst_flag = 1'b0;
      end
    end
    if (rfe_wr) begin
      rfe_d = wdat[WD_BIT_RFE];
    end
    if (wr & idx_hit(idx, WD_IDX_INT_EN)) begin
      ewdi_d = wdat[WD_BIT_EWDI];
    end
    if (tmo) begin
      ctl_d.flag = 1'b1;
    end
    // Reload run enable on any reset
    if (soft_rst) begin
      ctl_d.run_en = ~NV_WDOG_DISABLE_I;
      ctl_d.flag   = 1'b0;
      ewdi_d       = WD_EWDI_RST;
    end
    if (SYS_RESET_O) begin
      ctl_d.rst_flag = 1'b1;
    end
    ctl_d.clr = 1'b0;
  end

  always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      ctl_q   <= wd_ctl_one_t'(WD_CTL_ONE_RST);
      rfe_q   <= WD_RFE_RST;
      ewdi_q  <= WD_EWDI_RST;
      init_q  <= 1'b1;
      sleep_q <= 1'b0;
    end else begin
      ctl_q   <= ctl_d;
      rfe_q   <= rfe_d;
      ewdi_q  <= ewdi_d;
      init_q  <= 1'b0;
      sleep_q <= sleep;
    end
  end

  // Grace window before system reset
  always_comb begin
    st_d    = st_q;
    grace_d = grace_q;
    expire  = 1'b0;
    case (st_q)
      WD_ST_RUN: begin
        if (tmo & rfe_q) begin
          st_d    = WD_ST_GRACE;
          grace_d = '0;
        end
      end
      WD_ST_GRACE: begin
        if (cnt_clr) begin
          st_d = WD_ST_RUN;
        end else if (run_gate & LS_TICK_I) begin
          if (grace_q == WD_GRACE_LAST) begin
            expire = 1'b1;
            st_d   = WD_ST_RUN;
          end else begin
            grace_d = grace_q + WD_GRACE_W'(1);
          end
        end
      end
      default: begin
        st_d = WD_ST_RUN;
      end
    endcase
  end

  always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      st_q    <= WD_ST_RUN;
      grace_q <= '0;
    end else begin
      st_q    <= st_d;
      grace_q <= grace_d;
    end
  end

  // Bus answer and outputs
  always_comb begin
    ack_d = acc;
    dat_d = WB_DAT_O;
    if (acc) begin
      dat_d = '0;
      case (idx)
        WD_IDX_CTL_ONE: dat_d[7:0] = ctl_q;
        WD_IDX_CTL_TWO: dat_d[WD_BIT_RFE] = rfe_q;
        WD_IDX_INT_EN:  dat_d[WD_BIT_EWDI] = ewdi_q;
        default:        dat_d = '0;
      endcase
    end
    irq_d = ctl_q.flag & ewdi_q;
  end

  always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      WB_ACK_O    <= 1'b0;
      WB_DAT_O    <= '0;
      IRQ_O       <= 1'b0;
      WAKE_O      <= 1'b0;
      SYS_RESET_O <= 1'b0;
    end else begin
      WB_ACK_O    <= ack_d;
      WB_DAT_O    <= dat_d;
      IRQ_O       <= irq_d;
      WAKE_O      <= tmo;
      SYS_RESET_O <= expire;
    end
  end

  default clocking @(posedge REF_CLK_I); endclocking
  default disable iff (!RESET_N_I);

  sequence s_grace_open;
    st_q == WD_ST_RUN && tmo && rfe_q;
  endsequence

  sequence s_grace_last;
    st_q == WD_ST_GRACE && grace_q == WD_GRACE_LAST && run_gate && LS_TICK_I && !cnt_clr;
  endsequence

  a_stop_no_tmo: assert property (!ctl_q.run_en |-> !tmo)
    else $error("Time-out while disabled");
  a_flag_on_tmo: assert property (tmo && !soft_rst |=> ctl_q.flag)
    else $error("Flag not set by time-out");
  a_grace_start: assert property (s_grace_open |=> st_q == WD_ST_GRACE && grace_q == '0)
    else $error("Grace window not opened");
  a_grace_fires: assert property (s_grace_last |=> SYS_RESET_O ##1 ctl_q.rst_flag)
    else $error("No reset after grace window");
  a_clear_saves: assert property (st_q == WD_ST_GRACE && cnt_clr |=> st_q == WD_ST_RUN ##1 !SYS_RESET_O)
    else $error("Clear did not cancel reset");
  a_reset_needs_en: assert property ($rose(SYS_RESET_O) |-> $past(rfe_q, 2) && $past(st_q) == WD_ST_GRACE)
    else $error("Reset without reset function");
  a_wake_on_tmo: assert property (tmo |=> WAKE_O)
    else $error("No wake after time-out");
  a_sleep_halts: assert property (sleep && !ctl_q.sleep_run |-> !tmo)
    else $error("Counter ran in sleep");
  a_sleep_clears: assert property (sleep_edge |=> st_q == WD_ST_RUN)
    else $error("Sleep change did not clear");
  a_run_reload: assert property (soft_rst |=> ctl_q.run_en == !$past(NV_WDOG_DISABLE_I))
    else $error("Run enable not reloaded");
  a_keep_on_reset: assert property (OTHER_RESET_I && !ctl_wr && !rfe_wr |=> $stable(ctl_q.ps) && $stable(rfe_q))
    else $error("Setting lost on other reset");
  a_irq_gated: assert property (IRQ_O |-> $past(ewdi_q) && $past(ctl_q.flag))
    else $error("Interrupt without enable");
  a_key_needed: assert property (!$past(unlocked) && !soft_rst |-> ctl_q.ps == $past(ctl_q.ps))
    else $error("Protected write without key");
  a_flag_sticky: assert property (ctl_q.flag && !ctl_wr && !soft_rst |=> ctl_q.flag)
    else $error("Flag cleared by hardware");

endmodule : wd_watchdog

// [dv/wd_tb.sv]
// Self-checking bench for the watchdog timer block.
// Assumes one low-speed tick per clock; waits on ack as long as it takes.
`timescale 1ns/1ns
module testbench;
  import wd_pkg::*;
  logic        clk   = 1'b0;
  logic        rst_n = 1'b0;
  logic        cyc   = 1'b0;
  logic        stb   = 1'b0;
  logic        we    = 1'b0;
  logic [9:0]  adr   = 10'h000;
  logic [31:0] wdat  = 32'h0000_0000;
  logic [31:0] rdat;
  logic        ack;
  logic        tick  = 1'b1;
  logic        idle  = 1'b0;
  logic        pdn   = 1'b0;
  logic        nv    = 1'b0;
  logic        oth   = 1'b0;
  logic        irq;
  logic        wake;
  logic        sys_rst;
  logic [7:0]  junk;
  int          fails  = 0;
  int          checks = 0;

  always #10 clk = ~clk;

  wd_watchdog i_wd_watchdog (
    .REF_CLK_I(clk), .RESET_N_I(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(4'h1), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
    .LS_TICK_I(tick), .IDLE_I(idle), .PDOWN_I(pdn), .NV_WDOG_DISABLE_I(nv),
    .OTHER_RESET_I(oth), .IRQ_O(irq), .WAKE_O(wake), .SYS_RESET_O(sys_rst)
  );

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] r);
    @(posedge clk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= {a, 2'b00};
    wdat <= {24'h00_0000, d};
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    r = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    wb(1'b1, a, d, junk);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] r;
    wb(1'b0, a, 8'h00, r);
    chk({8'h00, r}, {8'h00, exp});
  endtask : rd

  task automatic ulw(input logic [7:0] a, input logic [7:0] d);
    wr(WD_IDX_KEY, WD_KEY_FIRST);
    wr(WD_IDX_KEY, WD_KEY_SECOND);
    wr(a, d);
  endtask : ulw

  // Cycles until wake (sel 0) or system reset (sel 1)
  task automatic win(input logic sel, input int lo, input int hi);
    int n;
    n = 0;
    while (((sel ? sys_rst : wake) !== 1'b1) && n < 40000) begin
      @(posedge clk);
      n++;
    end
    chk(16'(n >= lo && n <= hi), 16'h0001);
  endtask : win

  task automatic none(input logic sel, input int c);
    int k;
    k = 0;
    repeat (c) begin
      @(posedge clk);
      if ((sel ? sys_rst : wake) === 1'b1) k++;
    end
    chk(16'(k), 16'h0000);
  endtask : none

  task automatic pulse_other;
    @(posedge clk);
    oth <= 1'b1;
    @(posedge clk);
    oth <= 1'b0;
  endtask : pulse_other

  task automatic t_reset;
    rd(WD_IDX_CTL_ONE, 8'h80);
    rd(WD_IDX_CTL_TWO, 8'h00);
    rd(WD_IDX_INT_EN, 8'h00);
    rd(8'h10, 8'h00);
    rd(WD_IDX_KEY, 8'h00);
  endtask : t_reset

  task automatic t_lock;
    wr(WD_IDX_CTL_TWO, 8'h01);
    rd(WD_IDX_CTL_TWO, 8'h00);
    wr(WD_IDX_KEY, WD_KEY_FIRST);
    wr(WD_IDX_INT_EN, 8'h00);
    wr(WD_IDX_KEY, WD_KEY_SECOND);
    wr(WD_IDX_CTL_TWO, 8'h01);
    rd(WD_IDX_CTL_TWO, 8'h00);
  endtask : t_lock

  task automatic t_scale;
    int sh;
    int e;
    for (int s = 0; s < 8; s++) begin
      sh = (s < 2) ? s : s + 1;
      e = 64 << sh;
      ulw(WD_IDX_CTL_ONE, 8'hC0 | 8'(s));
      win(1'b0, e - 4, e + 4);
      repeat (3) @(posedge clk);
      rd(WD_IDX_CTL_ONE, 8'hA0 | 8'(s));
    end
  endtask : t_scale

  task automatic t_irq;
    wr(WD_IDX_INT_EN, 8'h10);
    repeat (2) @(posedge clk);
    chk({15'h0000, irq}, 16'h0001);
    ulw(WD_IDX_CTL_ONE, 8'hC0);
    repeat (2) @(posedge clk);
    chk({15'h0000, irq}, 16'h0000);
    wr(WD_IDX_INT_EN, 8'h00);
    win(1'b0, 50, 68);
    repeat (3) @(posedge clk);
    chk({15'h0000, irq}, 16'h0000);
  endtask : t_irq

  task automatic t_grace;
    ulw(WD_IDX_CTL_TWO, 8'h01);
    rd(WD_IDX_CTL_TWO, 8'h01);
    ulw(WD_IDX_CTL_ONE, 8'hC1);
    win(1'b0, 124, 132);
    repeat (300) @(posedge clk);
    ulw(WD_IDX_CTL_ONE, 8'hC1);
    none(1'b1, 250);
    win(1'b1, 385, 397);
    repeat (3) @(posedge clk);
    rd(WD_IDX_CTL_ONE, 8'h89);
    rd(WD_IDX_CTL_TWO, 8'h01);
    ulw(WD_IDX_CTL_ONE, 8'hC1);
    rd(WD_IDX_CTL_ONE, 8'h81);
    ulw(WD_IDX_CTL_TWO, 8'h00);
  endtask : t_grace

  task automatic t_other;
    ulw(WD_IDX_CTL_ONE, 8'hD3);
    nv <= 1'b1;
    pulse_other();
    rd(WD_IDX_CTL_ONE, 8'h13);
    none(1'b0, 600);
    nv <= 1'b0;
    pulse_other();
    rd(WD_IDX_CTL_ONE, 8'h93);
  endtask : t_other

  task automatic t_sleep;
    ulw(WD_IDX_CTL_ONE, 8'hC0);
    idle <= 1'b1;
    none(1'b0, 200);
    idle <= 1'b0;
    win(1'b0, 60, 68);
    ulw(WD_IDX_CTL_ONE, 8'hD0);
    repeat (40) @(posedge clk);
    pdn <= 1'b1;
    win(1'b0, 60, 68);
    repeat (30) @(posedge clk);
    pdn <= 1'b0;
    win(1'b0, 60, 68);
  endtask : t_sleep

  task automatic t_por;
    ulw(WD_IDX_CTL_TWO, 8'h01);
    ulw(WD_IDX_CTL_ONE, 8'h57);
    rd(WD_IDX_CTL_ONE, 8'h17);
    rd(WD_IDX_CTL_TWO, 8'h01);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    rd(WD_IDX_CTL_ONE, 8'h80);
    rd(WD_IDX_CTL_TWO, 8'h00);
  endtask : t_por

  task automatic wrap_up;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : wrap_up

  // Hang guard well past the longest time-out sweep
  initial begin
    #(20 * 80000);
    fails++;
    wrap_up();
  end

  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_lock();
    t_scale();
    t_irq();
    t_grace();
    t_other();
    t_sleep();
    t_por();
    wrap_up();
  end
endmodule : testbench
